// ===== core/ebps_top.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ebps_top (
  // Clock and reset
  input  wire logic                                CORE_CLK_IN,
  input  wire logic                                RST_IN,
  // Avalon-MM slave
  input  wire logic [ebps_pkg::AV_ADDR_W-1:0]      AVS_ADDRESS_IN,
  input  wire logic                                AVS_READ_IN,
  input  wire logic                                AVS_WRITE_IN,
  input  wire logic [ebps_pkg::AV_DATA_W-1:0]      AVS_WRITEDATA_IN,
  input  wire logic [3:0]                          AVS_BYTEENABLE_IN,
  output logic      [ebps_pkg::AV_DATA_W-1:0]      AVS_READDATA_OUT,
  output logic                                     AVS_WAITREQUEST_OUT,
  // Parallel port pins
  input  wire logic [ebps_pkg::PP_PINS-1:0]        PP_PIN_IN,
  output logic      [ebps_pkg::PP_PINS-1:0]        PP_PIN_OUT,
  output logic      [ebps_pkg::PP_PINS-1:0]        PP_PIN_OE_N_OUT,
  // LCD bridge
  input  wire logic [ebps_pkg::LCD_SIGS-1:0]       LCD_OUT_IN,
  input  wire logic [ebps_pkg::LCD_SIGS-1:0]       LCD_OE_IN,
  output logic      [ebps_pkg::LCD_SIGS-1:0]       LCD_IN_OUT,
  // SPI
  input  wire logic [ebps_pkg::SPI_SIGS-1:0]       SPI_OUT_IN,
  input  wire logic [ebps_pkg::SPI_SIGS-1:0]       SPI_OE_IN,
  output logic      [ebps_pkg::SPI_SIGS-1:0]       SPI_IN_OUT,
  // UART
  input  wire logic [ebps_pkg::UART_SIGS-1:0]      UART_OUT_IN,
  input  wire logic [ebps_pkg::UART_SIGS-1:0]      UART_OE_IN,
  output logic      [ebps_pkg::UART_SIGS-1:0]      UART_IN_OUT,
  // Audio serial instance 2
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST2_OUT_IN,
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST2_OE_IN,
  output logic      [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST2_IN_OUT,
  // Audio serial instance 3
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST3_OUT_IN,
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST3_OE_IN,
  output logic      [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST3_IN_OUT,
  // Parallel port GPIO
  input  wire logic [ebps_pkg::PP_GPIO_SIGS-1:0]   PP_GPIO_OUT_IN,
  input  wire logic [ebps_pkg::PP_GPIO_SIGS-1:0]   PP_GPIO_OE_IN,
  output logic      [ebps_pkg::PP_GPIO_SIGS-1:0]   PP_GPIO_IN_OUT,
  // Serial port 1 pins
  input  wire logic [ebps_pkg::SP1_PINS-1:0]       SP1_PIN_IN,
  output logic      [ebps_pkg::SP1_PINS-1:0]       SP1_PIN_OUT,
  output logic      [ebps_pkg::SP1_PINS-1:0]       SP1_PIN_OE_N_OUT,
  // Card interface instance 1
  input  wire logic [ebps_pkg::CARD_SIGS-1:0]      CARD_IFACE_INST1_OUT_IN,
  input  wire logic [ebps_pkg::CARD_SIGS-1:0]      CARD_IFACE_INST1_OE_IN,
  output logic      [ebps_pkg::CARD_SIGS-1:0]      CARD_IFACE_INST1_IN_OUT,
  // Audio serial instance 1
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST1_OUT_IN,
  input  wire logic [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST1_OE_IN,
  output logic      [ebps_pkg::AUD_SIGS-1:0]       AUDIO_SERIAL_INST1_IN_OUT,
  // GPIO lines 11 to 6
  input  wire logic [ebps_pkg::SP1_GPIO_SIGS-1:0]  GPIO_LINES_11_TO_6_OUT_IN,
  input  wire logic [ebps_pkg::SP1_GPIO_SIGS-1:0]  GPIO_LINES_11_TO_6_OE_IN,
  output logic      [ebps_pkg::SP1_GPIO_SIGS-1:0]  GPIO_LINES_11_TO_6_IN_OUT
);
  import ebps_pkg::*;

  logic [2:0]          parallel_port_route_field;
  logic [1:0]          serial_port1_route_field;
  logic [PP_SRCS-1:0]  pp_src_out;
  logic [PP_SRCS-1:0]  pp_src_oe;
  logic [PP_SRCS-1:0]  pp_src_in_d;
  logic [PP_SRCS-1:0]  pp_src_in_q;
  logic [SP1_SRCS-1:0] sp1_src_out;
  logic [SP1_SRCS-1:0] sp1_src_oe;
  logic [SP1_SRCS-1:0] sp1_src_in_d;
  logic [SP1_SRCS-1:0] sp1_src_in_q;

  ebps_sel_reg u_sel_reg (
    .clk_in          (CORE_CLK_IN),
    .rst_in          (RST_IN),
    .address_in      (AVS_ADDRESS_IN),
    .read_in         (AVS_READ_IN),
    .write_in        (AVS_WRITE_IN),
    .writedata_in    (AVS_WRITEDATA_IN),
    .byteenable_in   (AVS_BYTEENABLE_IN),
    .readdata_out    (AVS_READDATA_OUT),
    .waitrequest_out (AVS_WAITREQUEST_OUT),
    .pp_field_out    (parallel_port_route_field),
    .sp1_field_out   (serial_port1_route_field)
  );

  // Flatten peripheral groups so each port's table indexes every one of its own sources
  assign pp_src_out = {PP_GPIO_OUT_IN, AUDIO_SERIAL_INST3_OUT_IN,
                       AUDIO_SERIAL_INST2_OUT_IN, UART_OUT_IN, SPI_OUT_IN, LCD_OUT_IN};
  assign pp_src_oe  = {PP_GPIO_OE_IN, AUDIO_SERIAL_INST3_OE_IN,
                       AUDIO_SERIAL_INST2_OE_IN, UART_OE_IN, SPI_OE_IN, LCD_OE_IN};
  assign sp1_src_out = {GPIO_LINES_11_TO_6_OUT_IN, AUDIO_SERIAL_INST1_OUT_IN,
                        CARD_IFACE_INST1_OUT_IN};
  assign sp1_src_oe  = {GPIO_LINES_11_TO_6_OE_IN, AUDIO_SERIAL_INST1_OE_IN,
                        CARD_IFACE_INST1_OE_IN};

  assign LCD_IN_OUT                = pp_src_in_q[LCD_BASE +: LCD_SIGS];
  assign SPI_IN_OUT                = pp_src_in_q[SPI_BASE +: SPI_SIGS];
  assign UART_IN_OUT               = pp_src_in_q[UART_BASE +: UART_SIGS];
  assign AUDIO_SERIAL_INST2_IN_OUT = pp_src_in_q[AUD2_BASE +: AUD_SIGS];
  assign AUDIO_SERIAL_INST3_IN_OUT = pp_src_in_q[AUD3_BASE +: AUD_SIGS];
  assign PP_GPIO_IN_OUT            = pp_src_in_q[PPG_BASE +: PP_GPIO_SIGS];
  assign CARD_IFACE_INST1_IN_OUT   = sp1_src_in_q[CARD_BASE +: CARD_SIGS];
  assign AUDIO_SERIAL_INST1_IN_OUT = sp1_src_in_q[AUD1_BASE +: AUD_SIGS];
  assign GPIO_LINES_11_TO_6_IN_OUT = sp1_src_in_q[SPG_BASE +: SP1_GPIO_SIGS];

  // Map entry: valid bit then source index
  function automatic logic [6:0] src_at(input int base, input int off);
    src_at = {1'b1, 6'(base + off)};
  endfunction : src_at

  // Parallel port table; unlisted pins stay undriven
  function automatic logic [6:0] pp_map(input logic [2:0] mode, input int p);
    pp_map = 7'h00;
    case (mode)
      PP_MODE_LCD16: pp_map = src_at(LCD_BASE, p);
      PP_MODE_SPI_GPIO: begin
        if (p < 7)       pp_map = src_at(SPI_BASE, p);
        else if (p < 13) pp_map = src_at(PPG_BASE, p - 7);
        else if (p < 17) pp_map = src_at(UART_BASE, p - 13);
        else             pp_map = src_at(AUD2_BASE, p - 17);
      end
      PP_MODE_LCD8_GPIO: begin
        if (p < 8)       pp_map = src_at(LCD_BASE, p);
        else if (p < 16) pp_map = src_at(PPG_BASE, p - 8);
      end
      PP_MODE_LCD8_SPI: begin
        if (p < 8)       pp_map = src_at(LCD_BASE, p);
        else if (p < 12) pp_map = src_at(SPI_BASE, p - 8);
        else if (p < 16) pp_map = src_at(AUD3_BASE, p - 12);
      end
      PP_MODE_LCD8_AUD: begin
        if (p < 8)       pp_map = src_at(LCD_BASE, p);
        else if (p < 12) pp_map = src_at(AUD2_BASE, p - 8);
        else if (p < 16) pp_map = src_at(UART_BASE, p - 12);
      end
      PP_MODE_LCD8_UART: begin
        if (p < 8)       pp_map = src_at(LCD_BASE, p);
        else if (p < 12) pp_map = src_at(SPI_BASE, p - 8);
        else if (p < 16) pp_map = src_at(UART_BASE, p - 12);
      end
      PP_MODE_SPI_AUD: begin
        if (p < 7)       pp_map = src_at(SPI_BASE, p);
        else if (p < 11) pp_map = src_at(AUD2_BASE, p - 7);
        else if (p < 15) pp_map = src_at(AUD3_BASE, p - 11);
        else             pp_map = src_at(PPG_BASE, p - 15);
      end
      default: pp_map = 7'h00;
    endcase
  endfunction : pp_map

  // Serial port 1 table
  function automatic logic [6:0] sp1_map(input logic [1:0] mode, input int p);
    sp1_map = 7'h00;
    case (mode)
      SP1_MODE_CARD: sp1_map = src_at(CARD_BASE, p);
      SP1_MODE_AUD: begin
        if (p < 4) sp1_map = src_at(AUD1_BASE, p);
        else       sp1_map = src_at(SPG_BASE + SPG_LINE10, p - 4);
      end
      SP1_MODE_GPIO: sp1_map = src_at(SPG_BASE, p);
      default: sp1_map = 7'h00;
    endcase
  endfunction : sp1_map

  // Pin drivers are flops, so a field change shows one clock later
  for (genvar gp = 0; gp < PP_PINS; gp++) begin : g_pp_pin
    logic [6:0] ent;
    assign ent = pp_map(parallel_port_route_field, gp);
    always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
        PP_PIN_OUT[gp]      <= 1'b0;
        PP_PIN_OE_N_OUT[gp] <= 1'b1;
      end else if (ent[6]) begin
        PP_PIN_OUT[gp]      <= pp_src_out[ent[5:0]];
        PP_PIN_OE_N_OUT[gp] <= ~pp_src_oe[ent[5:0]];
      end else begin
        PP_PIN_OUT[gp]      <= 1'b0;
        PP_PIN_OE_N_OUT[gp] <= 1'b1;
      end
    end
  end

  for (genvar gs = 0; gs < SP1_PINS; gs++) begin : g_sp1_pin
    logic [6:0] ent;
    assign ent = sp1_map(serial_port1_route_field, gs);
    always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
        SP1_PIN_OUT[gs]      <= 1'b0;
        SP1_PIN_OE_N_OUT[gs] <= 1'b1;
      end else if (ent[6]) begin
        SP1_PIN_OUT[gs]      <= sp1_src_out[ent[3:0]];
        SP1_PIN_OE_N_OUT[gs] <= ~sp1_src_oe[ent[3:0]];
      end else begin
        SP1_PIN_OUT[gs]      <= 1'b0;
        SP1_PIN_OE_N_OUT[gs] <= 1'b1;
      end
    end
  end

  // Inbound path; unrouted peripheral inputs see zero
  always_comb begin
    logic [6:0] e;
    e = 7'h00;
    pp_src_in_d = '0;
    for (int p = 0; p < PP_PINS; p++) begin
      e = pp_map(parallel_port_route_field, p);
      if (e[6]) pp_src_in_d[e[5:0]] = PP_PIN_IN[p];
    end
  end

  always_comb begin
    logic [6:0] e;
    e = 7'h00;
    sp1_src_in_d = '0;
    for (int p = 0; p < SP1_PINS; p++) begin
      e = sp1_map(serial_port1_route_field, p);
      if (e[6]) sp1_src_in_d[e[3:0]] = SP1_PIN_IN[p];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      pp_src_in_q  <= '0;
      sp1_src_in_q <= '0;
    end else begin
      pp_src_in_q  <= pp_src_in_d;
      sp1_src_in_q <= sp1_src_in_d;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_pp_mode(logic [2:0] m);
    parallel_port_route_field == m;
  endsequence

  property p_lcd16;
    s_pp_mode(PP_MODE_LCD16) |=> (PP_PIN_OUT == $past(LCD_OUT_IN))
      && (PP_PIN_OE_N_OUT == ~$past(LCD_OE_IN));
  endproperty
  a_lcd16: assert property (p_lcd16)
    else $error("LCD16 routing mismatch");

  property p_spi_gpio;
    s_pp_mode(PP_MODE_SPI_GPIO) |=> (PP_PIN_OUT[6:0] == $past(SPI_OUT_IN))
      && (PP_PIN_OUT[12:7] == $past(PP_GPIO_OUT_IN[5:0]))
      && (PP_PIN_OUT[16:13] == $past(UART_OUT_IN))
      && (PP_PIN_OUT[20:17] == $past(AUDIO_SERIAL_INST2_OUT_IN));
  endproperty
  a_spi_gpio: assert property (p_spi_gpio)
    else $error("SPI GPIO routing mismatch");

  property p_lcd8_gpio;
    s_pp_mode(PP_MODE_LCD8_GPIO) |=> (PP_PIN_OUT[7:0] == $past(LCD_OUT_IN[7:0]))
      && (PP_PIN_OUT[15:8] == $past(PP_GPIO_OUT_IN)) && (&PP_PIN_OE_N_OUT[20:16]);
  endproperty
  a_lcd8_gpio: assert property (p_lcd8_gpio)
    else $error("LCD8 GPIO routing mismatch");

  property p_lcd8_spi;
    s_pp_mode(PP_MODE_LCD8_SPI) |=> (PP_PIN_OUT[11:8] == $past(SPI_OUT_IN[3:0]))
      && (PP_PIN_OUT[15:12] == $past(AUDIO_SERIAL_INST3_OUT_IN));
  endproperty
  a_lcd8_spi: assert property (p_lcd8_spi)
    else $error("LCD8 SPI routing mismatch");

  property p_lcd8_aud;
    s_pp_mode(PP_MODE_LCD8_AUD) |=> (PP_PIN_OUT[11:8] == $past(AUDIO_SERIAL_INST2_OUT_IN))
      && (PP_PIN_OUT[15:12] == $past(UART_OUT_IN));
  endproperty
  a_lcd8_aud: assert property (p_lcd8_aud)
    else $error("LCD8 audio routing mismatch");

  property p_lcd8_uart;
    s_pp_mode(PP_MODE_LCD8_UART) |=> (PP_PIN_OUT[7:0] == $past(LCD_OUT_IN[7:0]))
      && (PP_PIN_OUT[15:12] == $past(UART_OUT_IN));
  endproperty
  a_lcd8_uart: assert property (p_lcd8_uart)
    else $error("LCD8 UART routing mismatch");

  property p_spi_aud;
    s_pp_mode(PP_MODE_SPI_AUD) |=> (PP_PIN_OUT[10:7] == $past(AUDIO_SERIAL_INST2_OUT_IN))
      && (PP_PIN_OUT[14:11] == $past(AUDIO_SERIAL_INST3_OUT_IN))
      && (PP_PIN_OUT[20:15] == $past(PP_GPIO_OUT_IN[5:0]));
  endproperty
  a_spi_aud: assert property (p_spi_aud)
    else $error("SPI audio routing mismatch");

  property p_sp1_card;
    (serial_port1_route_field == SP1_MODE_CARD)
      |=> (SP1_PIN_OUT == $past(CARD_IFACE_INST1_OUT_IN));
  endproperty
  a_sp1_card: assert property (p_sp1_card)
    else $error("Card routing mismatch");

  property p_sp1_aud;
    (serial_port1_route_field == SP1_MODE_AUD)
      |=> (SP1_PIN_OUT[3:0] == $past(AUDIO_SERIAL_INST1_OUT_IN))
      && (SP1_PIN_OUT[5:4] == $past(GPIO_LINES_11_TO_6_OUT_IN[5:4]));
  endproperty
  a_sp1_aud: assert property (p_sp1_aud)
    else $error("Audio 1 routing mismatch");

  property p_sp1_gpio;
    (serial_port1_route_field == SP1_MODE_GPIO)
      |=> (SP1_PIN_OUT == $past(GPIO_LINES_11_TO_6_OUT_IN));
  endproperty
  a_sp1_gpio: assert property (p_sp1_gpio)
    else $error("GPIO routing mismatch");

  property p_switch_latency;
    ($changed(parallel_port_route_field) && (parallel_port_route_field == PP_MODE_RSVD))
      |-> !(&PP_PIN_OE_N_OUT) ##1 (&PP_PIN_OE_N_OUT);
  endproperty
  a_switch_latency: assert property (p_switch_latency)
    else $error("Routing change not one clock late");

  property p_reserved_idle;
    (s_pp_mode(PP_MODE_RSVD) |=> (&PP_PIN_OE_N_OUT) && (PP_PIN_OUT == '0))
      and ((serial_port1_route_field == SP1_MODE_RSVD) |=> (&SP1_PIN_OE_N_OUT));
  endproperty
  a_reserved_idle: assert property (p_reserved_idle)
    else $error("Reserved code left a pin driven");

endmodule : ebps_top

`default_nettype wire

// ===== core/ebps_pkg.sv
package ebps_pkg;

  // Bus geometry
  localparam int          AV_ADDR_W = 16;
  localparam int          AV_DATA_W = 32;
  localparam logic [15:0] ROUTE_SEL_ADDR = 16'h1c00;

  // Field layout of the route select register
  localparam int          RSVD_TOP_BIT = 15;
  localparam int          PP_FIELD_LSB = 12;
  localparam int          PP_FIELD_W   = 3;
  localparam int          SP1_FIELD_LSB = 10;
  localparam int          SP1_FIELD_W   = 2;
  localparam logic [2:0]  PP_FIELD_RST  = 3'h0;
  localparam logic [1:0]  SP1_FIELD_RST = 2'h0;

  // Parallel port route codes
  localparam logic [2:0]  PP_MODE_LCD16     = 3'h0;
  localparam logic [2:0]  PP_MODE_SPI_GPIO  = 3'h1;
  localparam logic [2:0]  PP_MODE_LCD8_GPIO = 3'h2;
  localparam logic [2:0]  PP_MODE_LCD8_SPI  = 3'h3;
  localparam logic [2:0]  PP_MODE_LCD8_AUD  = 3'h4;
  localparam logic [2:0]  PP_MODE_LCD8_UART = 3'h5;
  localparam logic [2:0]  PP_MODE_SPI_AUD   = 3'h6;
  localparam logic [2:0]  PP_MODE_RSVD      = 3'h7;

  // Serial port 1 route codes
  localparam logic [1:0]  SP1_MODE_CARD = 2'h0;
  localparam logic [1:0]  SP1_MODE_AUD  = 2'h1;
  localparam logic [1:0]  SP1_MODE_GPIO = 2'h2;
  localparam logic [1:0]  SP1_MODE_RSVD = 2'h3;

  // Pin and signal counts
  localparam int          PP_PINS   = 21;
  localparam int          SP1_PINS  = 6;
  localparam int          LCD_SIGS  = 21;
  localparam int          SPI_SIGS  = 7;
  localparam int          UART_SIGS = 4;
  localparam int          AUD_SIGS  = 4;
  localparam int          PP_GPIO_SIGS = 8;
  localparam int          CARD_SIGS = 6;
  localparam int          SP1_GPIO_SIGS = 6;

  // Positions inside the flattened parallel port source vector
  localparam int          LCD_BASE  = 0;
  localparam int          SPI_BASE  = 21;
  localparam int          UART_BASE = 28;
  localparam int          AUD2_BASE = 32;
  localparam int          AUD3_BASE = 36;
  localparam int          PPG_BASE  = 40;
  localparam int          PP_SRCS   = 48;

  // Positions inside the flattened serial port 1 source vector
  localparam int          CARD_BASE = 0;
  localparam int          AUD1_BASE = 6;
  localparam int          SPG_BASE  = 10;
  localparam int          SP1_SRCS  = 16;

  // Lines gpio_lines_11_10 sit at these slots of the serial GPIO group
  localparam int          SPG_LINE10 = 4;

endpackage : ebps_pkg

// ===== core/ebps_sel_reg.sv
`timescale 1ns/10ps
`default_nettype none

module ebps_sel_reg (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  // Avalon-MM slave
  input  wire logic [ebps_pkg::AV_ADDR_W-1:0]  address_in,
  input  wire logic                            read_in,
  input  wire logic                            write_in,
  input  wire logic [ebps_pkg::AV_DATA_W-1:0]  writedata_in,
  input  wire logic [3:0]                      byteenable_in,
  output logic      [ebps_pkg::AV_DATA_W-1:0]  readdata_out,
  output logic                                 waitrequest_out,
  // Fields
  output logic      [2:0]                      pp_field_out,
  output logic      [1:0]                      sp1_field_out
);
  import ebps_pkg::*;

  logic        ack_q;
  logic        hit;
  logic [31:0] readdata_q;
  logic [2:0]  pp_field_q;
  logic [1:0]  sp1_field_q;

  assign hit             = (address_in == ROUTE_SEL_ADDR);
  // One wait state, so read data can come from a flop
  assign waitrequest_out = (read_in | write_in) & ~ack_q;
  assign readdata_out    = readdata_q;
  assign pp_field_out    = pp_field_q;
  assign sp1_field_out   = sp1_field_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read_in | write_in) & ~ack_q;
    end
  end

  // Fields live in byte lane 1; top bit has no storage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pp_field_q  <= PP_FIELD_RST;
      sp1_field_q <= SP1_FIELD_RST;
    end else if (write_in && ack_q && hit && byteenable_in[1]) begin
      pp_field_q  <= writedata_in[PP_FIELD_LSB +: PP_FIELD_W];
      sp1_field_q <= writedata_in[SP1_FIELD_LSB +: SP1_FIELD_W];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      readdata_q <= 32'h0;
    end else if (read_in && !ack_q) begin
      readdata_q <= 32'h0;
      if (hit) begin
        readdata_q[RSVD_TOP_BIT] <= 1'b0;
        readdata_q[PP_FIELD_LSB +: PP_FIELD_W]   <= pp_field_q;
        readdata_q[SP1_FIELD_LSB +: SP1_FIELD_W] <= sp1_field_q;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_top_bit_zero;
    (read_in && ack_q) |-> (readdata_out[RSVD_TOP_BIT] == 1'b0);
  endproperty
  a_top_bit_zero: assert property (p_top_bit_zero)
    else $error("Reserved top bit read as one");

  property p_pp_write;
    (write_in && ack_q && hit && byteenable_in[1])
      |=> (pp_field_out == $past(writedata_in[14:12]));
  endproperty
  a_pp_write: assert property (p_pp_write)
    else $error("Parallel route field did not take written value");

  property p_sp1_write;
    (write_in && ack_q && hit && byteenable_in[1])
      |=> (sp1_field_out == $past(writedata_in[11:10]));
  endproperty
  a_sp1_write: assert property (p_sp1_write)
    else $error("Serial route field did not take written value");

endmodule : ebps_sel_reg

`default_nettype wire

// ===== tb/ebps_top_bench.sv
`timescale 1ns/10ps
`default_nettype none

module ebps_top_bench;
  import ebps_pkg::*;
  logic        CORE_CLK_IN, RST_IN, AVS_READ_IN, AVS_WRITE_IN;
  logic [15:0] AVS_ADDRESS_IN;
  logic [31:0] AVS_WRITEDATA_IN;
  logic [3:0]  AVS_BYTEENABLE_IN;
  logic [20:0] PP_PIN_IN;
  logic [5:0]  SP1_PIN_IN;
  wire  [31:0] AVS_READDATA_OUT;
  wire         AVS_WAITREQUEST_OUT;
  wire  [20:0] PP_PIN_OUT, PP_PIN_OE_N_OUT, LCD_OUT_IN, LCD_OE_IN, LCD_IN_OUT;
  wire  [6:0]  SPI_OUT_IN, SPI_OE_IN, SPI_IN_OUT;
  wire  [3:0]  UART_OUT_IN, UART_OE_IN, UART_IN_OUT;
  wire  [3:0]  AUDIO_SERIAL_INST1_OUT_IN, AUDIO_SERIAL_INST1_OE_IN, AUDIO_SERIAL_INST1_IN_OUT;
  wire  [3:0]  AUDIO_SERIAL_INST2_OUT_IN, AUDIO_SERIAL_INST2_OE_IN, AUDIO_SERIAL_INST2_IN_OUT;
  wire  [3:0]  AUDIO_SERIAL_INST3_OUT_IN, AUDIO_SERIAL_INST3_OE_IN, AUDIO_SERIAL_INST3_IN_OUT;
  wire  [7:0]  PP_GPIO_OUT_IN, PP_GPIO_OE_IN, PP_GPIO_IN_OUT;
  wire  [5:0]  SP1_PIN_OUT, SP1_PIN_OE_N_OUT;
  wire  [5:0]  CARD_IFACE_INST1_OUT_IN, CARD_IFACE_INST1_OE_IN, CARD_IFACE_INST1_IN_OUT;
  wire  [5:0]  GPIO_LINES_11_TO_6_OUT_IN, GPIO_LINES_11_TO_6_OE_IN, GPIO_LINES_11_TO_6_IN_OUT;
  logic [47:0] pv, po;
  logic [15:0] sv, so;
  logic [2:0]  pp_m;
  logic [1:0]  sp_m;
  logic [31:0] d;
  logic [144:0] e;
  logic        chk;
  logic [31:0] rd_q[$];
  logic [144:0] pin_q[$];
  integer      seed = 32'h549e;
  int          bad_count = 0, n_tests = 0, cyc = 0;

  // Source vectors laid out as the package bases
  assign {PP_GPIO_OUT_IN, AUDIO_SERIAL_INST3_OUT_IN, AUDIO_SERIAL_INST2_OUT_IN,
          UART_OUT_IN, SPI_OUT_IN, LCD_OUT_IN} = pv;
  assign {PP_GPIO_OE_IN, AUDIO_SERIAL_INST3_OE_IN, AUDIO_SERIAL_INST2_OE_IN,
          UART_OE_IN, SPI_OE_IN, LCD_OE_IN} = po;
  assign {GPIO_LINES_11_TO_6_OUT_IN, AUDIO_SERIAL_INST1_OUT_IN, CARD_IFACE_INST1_OUT_IN} = sv;
  assign {GPIO_LINES_11_TO_6_OE_IN, AUDIO_SERIAL_INST1_OE_IN, CARD_IFACE_INST1_OE_IN} = so;
  wire [63:0] ins = {GPIO_LINES_11_TO_6_IN_OUT, AUDIO_SERIAL_INST1_IN_OUT, CARD_IFACE_INST1_IN_OUT,
                     PP_GPIO_IN_OUT, AUDIO_SERIAL_INST3_IN_OUT, AUDIO_SERIAL_INST2_IN_OUT,
                     UART_IN_OUT, SPI_IN_OUT, LCD_IN_OUT};

  ebps_top ebps_top_inst (.*);

  initial begin
    CORE_CLK_IN = 1'b0;
    forever #50 CORE_CLK_IN = ~CORE_CLK_IN;
  end

  function automatic int ppmap(logic [2:0] m, int p);
    case (m)
      3'h0: return p;
      3'h1: return p < 7 ? SPI_BASE + p : p < 13 ? PPG_BASE + p - 7 :
                   p < 17 ? UART_BASE + p - 13 : AUD2_BASE + p - 17;
      3'h6: return p < 7 ? SPI_BASE + p : p < 11 ? AUD2_BASE + p - 7 :
                   p < 15 ? AUD3_BASE + p - 11 : PPG_BASE + p - 15;
      3'h7: return -1;
      default: begin
        if (p < 8) return p;
        if (p > 15) return -1;
        if (p < 12) return m == 3'h4 ? AUD2_BASE + p - 8 :
                           m == 3'h2 ? PPG_BASE + p - 8 : SPI_BASE + p - 8;
        return m == 3'h2 ? PPG_BASE + p - 8 : m == 3'h3 ? AUD3_BASE + p - 12 : UART_BASE + p - 12;
      end
    endcase
  endfunction : ppmap

  function automatic int spmap(logic [1:0] m, int p);
    case (m)
      2'h0: return p;
      2'h1: return p < 4 ? AUD1_BASE + p : SPG_BASE + p;
      2'h2: return SPG_BASE + p;
      default: return -1;
    endcase
  endfunction : spmap

  task automatic cmp(input logic [63:0] g, input logic [63:0] x);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic av(input logic w, input logic [15:0] a, input logic [31:0] dd,
                    input logic [3:0] be);
    AVS_ADDRESS_IN <= a;
    AVS_WRITEDATA_IN <= dd;
    AVS_BYTEENABLE_IN <= be;
    AVS_WRITE_IN <= w;
    AVS_READ_IN <= !w;
    do @(posedge CORE_CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
    AVS_WRITE_IN <= 1'b0;
    AVS_READ_IN <= 1'b0;
    @(posedge CORE_CLK_IN);
  endtask : av

  task automatic wr(input logic [15:0] a, input logic [31:0] dd, input logic [3:0] be);
    av(1'b1, a, dd, be);
    if (a == ROUTE_SEL_ADDR && be[1]) {pp_m, sp_m} = dd[14:10];
  endtask : wr

  // Only the two fields survive; bit 15 and the rest read zero
  task automatic rd(input logic [15:0] a);
    rd_q.push_back(a == ROUTE_SEL_ADDR ? {17'h0, pp_m, sp_m, 10'h0} : 32'h0);
    av(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  // Inputs settle for three edges, covering pin and peripheral register stages
  task automatic stim;
    logic [26:0] eo, ev, mk;
    logic [63:0] ei;
    int s;
    pv <= 48'({$random(seed), $random(seed)});
    po <= 48'({$random(seed), $random(seed)});
    sv <= 16'($random(seed));
    so <= 16'($random(seed));
    PP_PIN_IN <= 21'($random(seed));
    SP1_PIN_IN <= 6'($random(seed));
    repeat (3) @(posedge CORE_CLK_IN);
    eo = '1;
    ev = '0;
    mk = '1;
    ei = '0;
    for (int p = 0; p < 27; p++) begin
      s = p < 21 ? ppmap(pp_m, p) : spmap(sp_m, p - 21);
      if (s >= 0 && p < 21) begin
        {eo[p], ev[p], mk[p], ei[s]} = {~po[s], pv[s], po[s], PP_PIN_IN[p]};
      end
      if (s >= 0 && p > 20) begin
        {eo[p], ev[p], mk[p], ei[48 + s]} = {~so[s], sv[s], so[s], SP1_PIN_IN[p - 21]};
      end
    end
    pin_q.push_back({eo, ev, mk, ei});
    chk <= 1'b1;
    @(posedge CORE_CLK_IN);
    chk <= 1'b0;
  endtask : stim

  always @(posedge CORE_CLK_IN) begin
    if (AVS_READ_IN && AVS_WAITREQUEST_OUT === 1'b0) begin
      cmp(64'(AVS_READDATA_OUT), 64'(rd_q.pop_front()));
    end
  end

  always @(negedge CORE_CLK_IN) begin
    if (chk) begin
      e = pin_q.pop_front();
      cmp(64'({SP1_PIN_OE_N_OUT, PP_PIN_OE_N_OUT}), 64'(e[144:118]));
      cmp(64'({SP1_PIN_OUT, PP_PIN_OUT} & e[90:64]), 64'(e[117:91] & e[90:64]));
      cmp(ins, e[63:0]);
    end
  end

  always @(posedge CORE_CLK_IN) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict;
    end
  end

  initial begin
    {RST_IN, AVS_READ_IN, AVS_WRITE_IN, chk} = 4'h8;
    {AVS_ADDRESS_IN, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN} = '0;
    {pv, po, sv, so, PP_PIN_IN, SP1_PIN_IN} = '0;
    {pp_m, sp_m} = 5'h0;
    repeat (12) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    @(posedge CORE_CLK_IN);
    rd(ROUTE_SEL_ADDR);
    stim;
    for (int m = 0; m < 8; m++) begin
      d = $random(seed);
      d[15:10] = {1'b1, 3'(m), 2'(m)};
      wr(ROUTE_SEL_ADDR, d, 4'hf);
      rd(ROUTE_SEL_ADDR);
      // Fresh peripheral values only once the new routing stands
      stim;
      stim;
    end
    wr(ROUTE_SEL_ADDR, 32'h0, 4'hd);
    rd(ROUTE_SEL_ADDR);
    wr(16'h1c04, 32'h0000_4400, 4'hf);
    rd(16'h1c04);
    rd(ROUTE_SEL_ADDR);
    stim;
    give_verdict;
  end

endmodule : ebps_top_bench

`default_nettype wire
